// *** hw/rtc_map.vh ***
// Register indices, field positions, reset values and timing counts for the counter block
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// Register indices (byte address is four times the index)
`define RTC_IDX_COUNTER_CONTROL   5'h00
`define RTC_IDX_SYNC_STATUS       5'h01
`define RTC_IDX_IRQ_ENABLE        5'h02
`define RTC_IDX_IRQ_FLAGS         5'h03
`define RTC_IDX_WIDE_LATCH        5'h04
`define RTC_IDX_HALT_BEHAVIOUR    5'h05
`define RTC_IDX_ERROR_TRIM        5'h06
`define RTC_IDX_SOURCE_SELECT     5'h07
`define RTC_IDX_COUNT_VALUE       5'h08
`define RTC_IDX_WRAP_VALUE        5'h0A
`define RTC_IDX_MATCH_VALUE       5'h0C
`define RTC_IDX_PERIODIC_CONTROL  5'h10
`define RTC_IDX_PERIODIC_STATUS   5'h11
`define RTC_IDX_PERIODIC_IRQ_EN   5'h12
`define RTC_IDX_PERIODIC_IRQ_FLAG 5'h13
`define RTC_IDX_PERIODIC_HALT     5'h15

// Control fields
`define RTC_CTL_STANDBY_BIT   7
`define RTC_CTL_PRESC_HI      6
`define RTC_CTL_PRESC_LO      3
`define RTC_CTL_CORR_BIT      2
`define RTC_CTL_ENABLE_BIT    0
`define RTC_CTL_WRITE_MASK    8'hFD
`define RTC_PIT_PERIOD_HI     6
`define RTC_PIT_PERIOD_LO     3
`define RTC_PIT_ENABLE_BIT    0
`define RTC_PIT_WRITE_MASK    8'h79

// Status and flag bit positions
`define RTC_BUSY_MATCH        3
`define RTC_BUSY_WRAP         2
`define RTC_BUSY_COUNT        1
`define RTC_BUSY_CONTROL      0
`define RTC_IRQ_MATCH_BIT     1
`define RTC_IRQ_WRAP_BIT      0

// Reset values
`define RTC_RST_BYTE          8'h00
`define RTC_RST_WRAP          16'hFFFF
`define RTC_RST_WORD          16'h0000

// Counter clock ticks from register update to effect
`define RTC_SYNC_TICKS        2'h2

`endif

// *** hw/rtc_sync_edge.v ***
// Two-flop synchroniser for the slow counter clock pin with rising-edge tick
`timescale 1ns/1ns
module rtc_sync_edge (
  // Clock and reset
  input  wire sys_clk,
  input  wire rst_n,
  // Asynchronous level in
  input  wire asyncIn,
  // Synchronised rising-edge pulse out
  output wire risePulse
);

  reg meta_r;
  reg stable_r;
  reg prev_r;

  // Only stable_r reads meta_r
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r   <= 1'b0;
      stable_r <= 1'b0;
      prev_r   <= 1'b0;
    end else begin
      meta_r   <= asyncIn;
      stable_r <= meta_r;
      prev_r   <= stable_r;
    end
  end

  // One sys_clk pulse per counter clock rising edge
  assign risePulse = stable_r & ~prev_r;

endmodule // rtc_sync_edge

// *** hw/rtc_pit_core.v ***
// Real-time counter and periodic timer with APB register slave
//
// Behaviour
// R1 - Counter and periodic timer advance only on slow counter clock ticks, not bus clock.
// R2 - Status holds match, wrap, count and control busy flags at bits 3..0.
// R3 - Periodic status bit 0 is busy while periodic control crosses over.
// R4 - Software waits for the busy flag to clear before rewriting that register.
// R5 - Run-when-halted set keeps the counter counting during CPU debug halt.
// R6 - Run-when-halted clear stops the counter and its events during halt.
// R7 - Periodic output forced low during halt unless its own run bit set.
// R8 - Resuming with output high yields a fresh rising edge, one extra flag.
// R9 - Resuming with output low stays low, no additional flag.
// R10 - Prescaler field 6:3 divides counter clock by two to that power.
// R11 - Control writes reach the counter side two counter clock ticks later.
// R12 - Control bit 7 keeps the counter running in standby, clear disables it.
// R13 - Control bit 2 enables crystal error correction of the prescaler.
// R14 - Control bit 0 enables the counter; control resets to zero.
// R15 - Interrupt enable bit 1 match, bit 0 wrap; resets to zero.
// R16 - Match flag bit 1 sets on count equal compare; write one clears.
// R17 - Wrap flag bit 0 sets when count reaches period and wraps; write one clears.
// R18 - Interrupt request high while enable and flag both set, until flag cleared.
// R19 - Shared prescaler stops when both functions disabled, runs if either enabled.
// R20 - Busy sets on bus write, clears after capture and returned acknowledge.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`include "rtc_map.vh"
module rtc_pit_core #(
  parameter CNT_W  = 16,
  parameter PRE_W  = 15,
  parameter CORR_W = 20
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Slow counter clock pin
  input  wire        counterClk,
  // System state from the same clock domain
  input  wire        cpuHalted,
  input  wire        standbySleep,
  // Requests and periodic output
  output wire        counterIrq,
  output wire        periodicIrq,
  output reg         periodicOut
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus-side registers
  reg [7:0]       control_r;
  reg [1:0]       irqEnable_r;
  reg [1:0]       irqFlags_r;
  reg [7:0]       wideLatch_r;
  reg             runHalted_r;
  reg [7:0]       errorTrim_r;
  reg [1:0]       sourceSel_r;
  reg [CNT_W-1:0] countWr_r;
  reg [CNT_W-1:0] wrapWr_r;
  reg [CNT_W-1:0] matchWr_r;
  reg [7:0]       periodic_r;
  reg             periodicIrqEn_r;
  reg             periodicFlag_r;
  reg             periodicRunHalted_r;

  // Sync state: index 0 control, 1 count, 2 wrap, 3 match, 4 periodic
  reg [4:0]       busy_r;
  reg [9:0]       stage_r;

  // Counter-side shadows
  reg [7:0]       ctlShadow_r;
  reg [7:0]       pitShadow_r;
  reg [CNT_W-1:0] wrapShadow_r;
  reg [CNT_W-1:0] matchShadow_r;
  reg [CNT_W-1:0] count_r;
  reg [PRE_W-1:0] presc_r;
  reg [CORR_W-1:0] corrCnt_r;
  reg             corrActive_r;

  wire            slowTick;
  wire [4:0]      busEnd;
  wire [4:0]      loadNow;
  wire            setupRd;
  wire            accessWr;
  wire [4:0]      regIdx;
  wire            wordAligned;

  ////////////////////////////////////////////////////////////////////////////
  // Counter clock pin crossing
  rtc_sync_edge uSync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .asyncIn   (counterClk),
    .risePulse (slowTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: no wait states, writes land in the access cycle
  assign pready      = psel & penable;
  assign pslverr     = 1'b0;
  assign setupRd     = psel & ~penable & ~pwrite;
  assign accessWr    = psel & penable & pwrite;
  assign regIdx      = paddr[6:2];
  assign wordAligned = (paddr[1:0] == 2'h0) & ~paddr[7];

  // Decode a write strobe for one register index
  function wrHit;
    input [4:0] idx;
    input [4:0] want;
    input       strobe;
    input       aligned;
    begin
      wrHit = strobe & aligned & (idx == want);
    end
  endfunction

  // Advance a sync stage on counter ticks; stage 2 is the returned ack
  function [1:0] stageNext;
    input       busy;
    input [1:0] stage;
    input       tick;
    begin
      if (!busy) begin
        stageNext = 2'h0;
      end else if (stage == `RTC_SYNC_TICKS) begin
        stageNext = 2'h0;
      end else if (tick) begin
        stageNext = stage + 2'h1;
      end else begin
        stageNext = stage;
      end
    end
  endfunction

  assign busEnd[0] = wrHit(regIdx, `RTC_IDX_COUNTER_CONTROL, accessWr, wordAligned);
  assign busEnd[1] = wrHit(regIdx, `RTC_IDX_COUNT_VALUE, accessWr, wordAligned);
  assign busEnd[2] = wrHit(regIdx, `RTC_IDX_WRAP_VALUE, accessWr, wordAligned);
  assign busEnd[3] = wrHit(regIdx, `RTC_IDX_MATCH_VALUE, accessWr, wordAligned);
  assign busEnd[4] = wrHit(regIdx, `RTC_IDX_PERIODIC_CONTROL, accessWr, wordAligned);

  ////////////////////////////////////////////////////////////////////////////
  // Read data captured in the setup cycle
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (setupRd) begin
      prdata <= 32'h00000000;
      if (wordAligned) begin
        case (regIdx)
          `RTC_IDX_COUNTER_CONTROL:   prdata[7:0] <= control_r;
          `RTC_IDX_SYNC_STATUS:       prdata[3:0] <= {busy_r[3], busy_r[2], busy_r[1],
                                                      busy_r[0]}; // [R2]
          `RTC_IDX_IRQ_ENABLE:        prdata[1:0] <= irqEnable_r;
          `RTC_IDX_IRQ_FLAGS:         prdata[1:0] <= irqFlags_r;
          `RTC_IDX_WIDE_LATCH:        prdata[7:0] <= wideLatch_r;
          `RTC_IDX_HALT_BEHAVIOUR:    prdata[0]   <= runHalted_r;
          `RTC_IDX_ERROR_TRIM:        prdata[7:0] <= errorTrim_r;
          `RTC_IDX_SOURCE_SELECT:     prdata[1:0] <= sourceSel_r;
          `RTC_IDX_COUNT_VALUE:       prdata[CNT_W-1:0] <= count_r;
          `RTC_IDX_WRAP_VALUE:        prdata[CNT_W-1:0] <= wrapWr_r;
          `RTC_IDX_MATCH_VALUE:       prdata[CNT_W-1:0] <= matchWr_r;
          `RTC_IDX_PERIODIC_CONTROL:  prdata[7:0] <= periodic_r;
          `RTC_IDX_PERIODIC_STATUS:   prdata[0]   <= busy_r[4]; // [R3]
          `RTC_IDX_PERIODIC_IRQ_EN:   prdata[0]   <= periodicIrqEn_r;
          `RTC_IDX_PERIODIC_IRQ_FLAG: prdata[0]   <= periodicFlag_r;
          `RTC_IDX_PERIODIC_HALT:     prdata[0]   <= periodicRunHalted_r;
          default:                    prdata      <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain bus-side configuration registers
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      control_r           <= `RTC_RST_BYTE; // [R14]
      irqEnable_r         <= 2'h0; // [R15]
      wideLatch_r         <= `RTC_RST_BYTE;
      runHalted_r         <= 1'b0;
      errorTrim_r         <= `RTC_RST_BYTE;
      sourceSel_r         <= 2'h0;
      countWr_r           <= `RTC_RST_WORD;
      wrapWr_r            <= `RTC_RST_WRAP;
      matchWr_r           <= `RTC_RST_WORD;
      periodic_r          <= `RTC_RST_BYTE;
      periodicIrqEn_r     <= 1'b0;
      periodicRunHalted_r <= 1'b0;
    end else begin
      if (busEnd[0]) begin
        control_r <= pwdata[7:0] & `RTC_CTL_WRITE_MASK;
      end
      if (wrHit(regIdx, `RTC_IDX_IRQ_ENABLE, accessWr, wordAligned)) begin
        irqEnable_r <= pwdata[1:0]; // [R15]
      end
      if (wrHit(regIdx, `RTC_IDX_WIDE_LATCH, accessWr, wordAligned)) begin
        wideLatch_r <= pwdata[7:0];
      end
      if (wrHit(regIdx, `RTC_IDX_HALT_BEHAVIOUR, accessWr, wordAligned)) begin
        runHalted_r <= pwdata[0];
      end
      if (wrHit(regIdx, `RTC_IDX_ERROR_TRIM, accessWr, wordAligned)) begin
        errorTrim_r <= pwdata[7:0];
      end
      if (wrHit(regIdx, `RTC_IDX_SOURCE_SELECT, accessWr, wordAligned)) begin
        sourceSel_r <= pwdata[1:0];
      end
      if (busEnd[1]) begin
        countWr_r <= pwdata[CNT_W-1:0];
      end
      if (busEnd[2]) begin
        wrapWr_r <= pwdata[CNT_W-1:0];
      end
      if (busEnd[3]) begin
        matchWr_r <= pwdata[CNT_W-1:0];
      end
      if (busEnd[4]) begin
        periodic_r <= pwdata[7:0] & `RTC_PIT_WRITE_MASK;
      end
      if (wrHit(regIdx, `RTC_IDX_PERIODIC_IRQ_EN, accessWr, wordAligned)) begin
        periodicIrqEn_r <= pwdata[0];
      end
      if (wrHit(regIdx, `RTC_IDX_PERIODIC_HALT, accessWr, wordAligned)) begin
        periodicRunHalted_r <= pwdata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy flags: set on write, load after two ticks, clear on the ack stage
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gSync
      assign loadNow[gi] = busy_r[gi] & slowTick
                         & (stage_r[2*gi+1:2*gi] == `RTC_SYNC_TICKS - 2'h1); // [R11]
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          busy_r[gi]            <= 1'b0;
          stage_r[2*gi+1:2*gi]  <= 2'h0;
        end else if (busEnd[gi]) begin
          busy_r[gi]            <= 1'b1; // [R20]
          stage_r[2*gi+1:2*gi]  <= 2'h0;
        end else begin
          if (busy_r[gi] && stage_r[2*gi+1:2*gi] == `RTC_SYNC_TICKS) begin
            busy_r[gi] <= 1'b0; // [R20]
          end
          stage_r[2*gi+1:2*gi]  <= stageNext(busy_r[gi], stage_r[2*gi+1:2*gi], slowTick);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Counter-side decode
  wire [3:0] prescSel  = ctlShadow_r[`RTC_CTL_PRESC_HI:`RTC_CTL_PRESC_LO];
  wire [3:0] periodSel = pitShadow_r[`RTC_PIT_PERIOD_HI:`RTC_PIT_PERIOD_LO];
  wire       cntOn     = ctlShadow_r[`RTC_CTL_ENABLE_BIT]; // [R14]
  wire       pitOn     = pitShadow_r[`RTC_PIT_ENABLE_BIT];
  wire       prescRun  = cntOn | pitOn; // [R19]
  wire       cntHalt   = cpuHalted & ~runHalted_r; // [R5] [R6]
  wire       cntSleep  = standbySleep & ~ctlShadow_r[`RTC_CTL_STANDBY_BIT]; // [R12]
  wire       cntRun    = cntOn & ~cntHalt & ~cntSleep;
  wire       pitHalt   = cpuHalted & ~periodicRunHalted_r; // [R7]

  // Division by two to the field: tick when low bits of prescaler are all ones
  wire [PRE_W:0] lowMask = ({{PRE_W{1'b0}}, 1'b1} << prescSel) - {{PRE_W{1'b0}}, 1'b1};
  wire       divHit    = ((presc_r & lowMask[PRE_W-1:0]) == lowMask[PRE_W-1:0]); // [R10]

  // Correction slots at the start of the interval, one per 8192 ticks for the first corrErr slots
  wire [6:0] corrErr   = errorTrim_r[6:0];
  wire       corrSign  = errorTrim_r[7];
  wire       corrSlot  = (corrCnt_r[12:0] == 13'h0000) & (corrCnt_r[19:13] < corrErr);
  wire       doCorr    = corrActive_r & corrSlot & slowTick; // [R13]

  // A skipped prescaler step also holds the count tick; a doubled step still ticks the count once
  wire       cntTick   = slowTick & cntRun & divHit & ~(doCorr & ~corrSign);

  ////////////////////////////////////////////////////////////////////////////
  // Shadow loads and shared prescaler
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ctlShadow_r   <= `RTC_RST_BYTE;
      pitShadow_r   <= `RTC_RST_BYTE;
      wrapShadow_r  <= `RTC_RST_WRAP;
      matchShadow_r <= `RTC_RST_WORD;
      presc_r       <= {PRE_W{1'b0}};
      corrCnt_r     <= {CORR_W{1'b0}};
      corrActive_r  <= 1'b0;
    end else begin
      if (loadNow[0]) ctlShadow_r   <= control_r; // [R1] [R11]
      if (loadNow[2]) wrapShadow_r  <= wrapWr_r;
      if (loadNow[3]) matchShadow_r <= matchWr_r;
      if (loadNow[4]) pitShadow_r   <= periodic_r;
      // Ongoing interval finishes before correction turns off
      if (ctlShadow_r[`RTC_CTL_CORR_BIT]) begin
        corrActive_r <= 1'b1; // [R13]
      end else if (slowTick && corrCnt_r == {CORR_W{1'b1}}) begin
        corrActive_r <= 1'b0;
      end
      if (!prescRun) begin
        presc_r <= {PRE_W{1'b0}}; // [R19]
      end else if (slowTick) begin
        corrCnt_r <= corrCnt_r + {{(CORR_W-1){1'b0}}, 1'b1};
        if (doCorr && !corrSign) begin
          presc_r <= presc_r; // Slower: hold one step
        end else if (doCorr) begin
          presc_r <= presc_r + {{(PRE_W-2){1'b0}}, 2'h2}; // Faster: extra step
        end else begin
          presc_r <= presc_r + {{(PRE_W-1){1'b0}}, 1'b1}; // [R1]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count, wrap and match; set wins over software clear
  wire wrapNow  = cntTick & (count_r == wrapShadow_r);
  wire matchNow = cntTick & (count_r == matchShadow_r);
  wire [1:0] flagClr = wrHit(regIdx, `RTC_IDX_IRQ_FLAGS, accessWr, wordAligned)
                     ? pwdata[1:0] : 2'h0;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      count_r    <= `RTC_RST_WORD;
      irqFlags_r <= 2'h0;
    end else begin
      if (loadNow[1]) begin
        count_r <= countWr_r; // [R11]
      end else if (wrapNow) begin
        count_r <= {CNT_W{1'b0}}; // [R17]
      end else if (cntTick) begin
        count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1}; // [R6]
      end
      irqFlags_r[`RTC_IRQ_MATCH_BIT] <= matchNow
                                      | (irqFlags_r[`RTC_IRQ_MATCH_BIT]
                                         & ~flagClr[`RTC_IRQ_MATCH_BIT]); // [R16]
      irqFlags_r[`RTC_IRQ_WRAP_BIT]  <= wrapNow
                                      | (irqFlags_r[`RTC_IRQ_WRAP_BIT]
                                         & ~flagClr[`RTC_IRQ_WRAP_BIT]); // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Periodic output: code k follows prescaler bit k-1, code 0 stays low
  wire [3:0] pitBit  = periodSel - 4'h1;
  wire       pitRaw  = pitOn & (periodSel != 4'h0) & (pitBit < PRE_W) & presc_r[pitBit];
  wire       pitGate = pitRaw & ~pitHalt; // [R7]
  wire       pitClr  = wrHit(regIdx, `RTC_IDX_PERIODIC_IRQ_FLAG, accessWr, wordAligned)
                     & pwdata[0];
  wire       pitRise = pitGate & ~periodicOut; // [R8] [R9]

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      periodicOut    <= 1'b0;
      periodicFlag_r <= 1'b0;
    end else begin
      periodicOut    <= pitGate; // [R7]
      periodicFlag_r <= pitRise | (periodicFlag_r & ~pitClr); // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests held until the flag is cleared
  assign counterIrq  = |(irqEnable_r & irqFlags_r); // [R18]
  assign periodicIrq = periodicIrqEn_r & periodicFlag_r; // [R18]

endmodule // rtc_pit_core

// *** sim/rtc_pit_assertions.sv ***
// Port assertions for the counter and periodic timer block
`timescale 1ns/1ns
`include "rtc_map.vh"
module rtc_pit_assertions #(
  parameter CNT_W  = 16,
  parameter PRE_W  = 15,
  parameter CORR_W = 20
) (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Side pins
  input wire        counterClk,
  input wire        cpuHalted,
  input wire        standbySleep,
  input wire        counterIrq,
  input wire        periodicIrq,
  input wire        periodicOut
);
  localparam [7:0] CTL = `RTC_IDX_COUNTER_CONTROL << 2;
  localparam [7:0] STA = `RTC_IDX_SYNC_STATUS << 2;
  localparam [7:0] CNV = `RTC_IDX_COUNT_VALUE << 2;
  localparam [7:0] PHL = `RTC_IDX_PERIODIC_HALT << 2;
  wire       accW = psel && penable && pwrite;
  wire       accR = psel && penable && !pwrite;
  reg  [7:0] ctlWr_r;
  reg        periodicRunWr_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Last control byte and periodic run-when-halted bit written over the bus
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ctlWr_r         <= 8'h00;
      periodicRunWr_r <= 1'b0;
    end else begin
      if (accW && paddr == CTL)
        ctlWr_r <= pwdata[7:0];
      if (accW && paddr == PHL)
        periodicRunWr_r <= pwdata[0];
    end
  end
  // Protocol, reset and register checks
  a_ready_access: assert property (pready == (psel && penable))
    else $error("pready does not match the access phase");
  a_reset_quiet: assert property ($rose(rst_n) |-> !counterIrq && !periodicIrq && !periodicOut)
    else $error("request or output high after reset");
  a_irq_drop: assert property ($fell(counterIrq) |-> $past(accW) || $past(!rst_n))
    else $error("counter request fell without a bus write");
  a_pirq_drop: assert property ($fell(periodicIrq) |-> $past(accW) || $past(!rst_n))
    else $error("periodic request fell without a bus write");
  a_busy_seen: assert property (accW && paddr == CNV ##2 psel && !penable && paddr == STA
    ##1 accR |-> prdata[`RTC_BUSY_COUNT]) else $error("count busy not seen after write");
  a_refused_read: assert property (accR && (paddr[1:0] != 2'h0 || paddr[7]) |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_read_hold: assert property (accR |=> $stable(prdata))
    else $error("read data changed after access");
  a_no_error: assert property (pready |-> !pslverr)
    else $error("slave error raised");
  a_halt_low: assert property ($past(cpuHalted) && !$past(periodicRunWr_r)
    |-> !periodicOut) else $error("periodic output high while halted");
  a_ctrl_back: assert property (psel && !penable && paddr == CTL ##1 accR
    |-> prdata[7:0] == (ctlWr_r & `RTC_CTL_WRITE_MASK)) else $error("control readback wrong");
  // Main scenarios
  c_counter_req: cover property ($rose(counterIrq));
  c_periodic_req: cover property ($rose(periodicIrq));
  c_halted_low: cover property (cpuHalted && $fell(periodicOut));
endmodule // rtc_pit_assertions

bind rtc_pit_core rtc_pit_assertions #(.CNT_W(CNT_W), .PRE_W(PRE_W), .CORR_W(CORR_W)) i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .counterClk(counterClk), .cpuHalted(cpuHalted), .standbySleep(standbySleep),
  .counterIrq(counterIrq), .periodicIrq(periodicIrq), .periodicOut(periodicOut)
);

// *** sim/rtc_pit_sync_debug_regs_tb_top.sv ***
// Self-checking bench for the counter and periodic timer block
`timescale 1ns/1ns
`include "rtc_map.vh"
module rtc_pit_sync_debug_regs_tb_top;
  localparam [7:0] CTL = `RTC_IDX_COUNTER_CONTROL << 2;
  localparam [7:0] STA = `RTC_IDX_SYNC_STATUS << 2;
  localparam [7:0] IEN = `RTC_IDX_IRQ_ENABLE << 2;
  localparam [7:0] IFL = `RTC_IDX_IRQ_FLAGS << 2;
  localparam [7:0] HLT = `RTC_IDX_HALT_BEHAVIOUR << 2;
  localparam [7:0] CNV = `RTC_IDX_COUNT_VALUE << 2;
  localparam [7:0] WRP = `RTC_IDX_WRAP_VALUE << 2;
  localparam [7:0] MTC = `RTC_IDX_MATCH_VALUE << 2;
  localparam [7:0] PCT = `RTC_IDX_PERIODIC_CONTROL << 2;
  localparam [7:0] PST = `RTC_IDX_PERIODIC_STATUS << 2;
  localparam [7:0] PIE = `RTC_IDX_PERIODIC_IRQ_EN << 2;
  localparam [7:0] PIF = `RTC_IDX_PERIODIC_IRQ_FLAG << 2;
  localparam [7:0] PHL = `RTC_IDX_PERIODIC_HALT << 2;
  // Drive and observe
  reg          sys_clk, rst_n, psel, penable, pwrite;
  reg          counterClk, cpuHalted, standbySleep;
  reg   [7:0]  paddr;
  reg   [31:0] pwdata;
  wire         pready, pslverr, counterIrq, periodicIrq, periodicOut;
  wire  [31:0] prdata;
  logic [31:0] rdVal, base;
  int          errCount = 0;
  int          checksDone = 0;

  rtc_pit_core i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .counterClk(counterClk), .cpuHalted(cpuHalted), .standbySleep(standbySleep),
    .counterIrq(counterIrq), .periodicIrq(periodicIrq), .periodicOut(periodicOut)
  );
  ////////////////////////////////////////
  // Bus clock
  always #5 sys_clk = ~sys_clk;
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp || ^exp === 1'bx) begin
      errCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer, read data kept in rdVal
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1) @(posedge sys_clk);
    rdVal = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Write, and read with compare
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(rdVal, e);
  endtask
  // Slow clock pulses, four bus cycles per phase
  task automatic tick(input int n);
    repeat (n) begin
      counterClk <= 1'h1;
      repeat (4) @(posedge sys_clk);
      counterClk <= 1'h0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  // Tick until no crossing is pending
  task automatic idle;
    repeat (20) begin
      apb(1'h0, STA, 32'h0);
      base = rdVal;
      apb(1'h0, PST, 32'h0);
      if (base === 32'h0 && rdVal === 32'h0) break;
      tick(1);
    end
  endtask
  // Count advance over n slow ticks
  task automatic span(input int n, input int adv, input int m);
    apb(1'h0, CNV, 32'h0);
    base = rdVal;
    tick(n);
    rc(CNV, (base + adv) % m);
  endtask
  ////////////////////////////////////////
  // Reset values and refused places
  task automatic resetVals;
    rc(CTL, 32'h0);
    rc(STA, 32'h0);
    rc(IEN, 32'h0);
    rc(IFL, 32'h0);
    rc(WRP, 32'hFFFF);
    rc(PST, 32'h0);
    wr(8'h38, 32'h55);
    rc(8'h38, 32'h0);
    rc(8'h81, 32'h0);
    wr(STA, 32'hF);
    rc(STA, 32'h0);
  endtask
  // Busy flags across the two-tick crossing
  task automatic syncFlags;
    wr(CTL, 32'hFF);
    wr(WRP, 32'h3);
    wr(MTC, 32'h2);
    wr(CNV, 32'h0);
    rc(STA, 32'hF);
    tick(1);
    rc(STA, 32'hF);
    tick(1);
    rc(STA, 32'h0);
    rc(CTL, 32'hFD);
    wr(PCT, 32'h8);
    rc(PST, 32'h1);
    tick(2);
    rc(PST, 32'h0);
  endtask
  // Wrap and match flags, clearing, request line, prescaler
  task automatic countFlags;
    wr(CTL, 32'h1);
    wr(IEN, 32'h3);
    idle();
    rc(IEN, 32'h3);
    wr(IFL, 32'h3);
    span(5, 5, 4);
    rc(IFL, 32'h3);
    wr(IFL, 32'h0);
    rc(IFL, 32'h3);
    wr(IFL, 32'h1);
    rc(IFL, 32'h2);
    #1 check(counterIrq, 1'h1);
    wr(IEN, 32'h1);
    #1 check(counterIrq, 1'h0);
    wr(IFL, 32'h2);
    rc(IFL, 32'h0);
    wr(WRP, 32'hFF);
    wr(CTL, 32'h9);
    idle();
    span(8, 4, 65536);
    wr(CTL, 32'h79);
    idle();
    span(6, 0, 65536);
    wr(CTL, 32'h0);
    idle();
    span(4, 0, 65536);
  endtask
  // Debug halt and standby gating of the count
  task automatic haltSleep;
    wr(CTL, 32'h1);
    idle();
    cpuHalted <= 1'h1;
    span(3, 0, 65536);
    wr(HLT, 32'h1);
    span(3, 3, 65536);
    cpuHalted <= 1'h0;
    standbySleep <= 1'h1;
    span(3, 0, 65536);
    wr(CTL, 32'h81);
    idle();
    span(3, 3, 65536);
    standbySleep <= 1'h0;
  endtask
  // Periodic output across debug breaks
  task automatic periodic;
    wr(CTL, 32'h0);
    wr(PIE, 32'h1);
    wr(PCT, 32'h9);
    idle();
    if (periodicOut !== 1'h1) tick(1);
    wr(PIF, 32'h1);
    cpuHalted <= 1'h1;
    repeat (3) @(posedge sys_clk);
    #1 check(periodicOut, 1'h0);
    @(posedge sys_clk);
    cpuHalted <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rc(PIF, 32'h1);
    #1 check(periodicIrq, 1'h1);
    wr(PIF, 32'h1);
    #1 check(periodicIrq, 1'h0);
    @(posedge sys_clk);
    tick(1);
    #1 check(periodicOut, 1'h0);
    @(posedge sys_clk);
    cpuHalted <= 1'h1;
    repeat (3) @(posedge sys_clk);
    cpuHalted <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rc(PIF, 32'h0);
    wr(PHL, 32'h1);
    cpuHalted <= 1'h1;
    tick(2);
    rc(PIF, 32'h1);
    cpuHalted <= 1'h0;
  endtask
  // Counts, verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog, well past the expected run of some 8000 ns
  initial begin
    #100000;
    errCount++;
    results();
  end
  // Reset for five cycles, then each scenario
  initial begin
    sys_clk = 1'h0;
    rst_n = 1'h0;
    {psel, penable, pwrite, counterClk, cpuHalted, standbySleep} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    resetVals();
    syncFlags();
    countFlags();
    haltSleep();
    periodic();
    results();
  end
endmodule // rtc_pit_sync_debug_regs_tb_top
